//--- half_cycle_tone_packet_codec.sv
// Serial-to-tone packet encoder and tone-to-serial packet decoder of a radio modem.
// Behaviour
// - The tone is made of half-cycles of 500 us (long) or 250 us (short), and each received half is classified.
// - Without a packet to send the encoder sends only long halves, an idle 1 kHz tone.
// - Each packet opens with one long, twelve shorts and one long, which the decoder hunts for.
// - Twelve data groups of four halves follow the sync, and the decoder collects all twelve.
// - Each group carries two bits, four groups make a byte, a packet carries three bytes.
// - Only four of the sixteen group combinations carry data and are accepted as data.
// - A group that is neither data nor all-long throws the whole packet away.
// - An all-long group is null data; a byte slot of four of them does not spoil the packet, so short packets still deliver.
// - Every half-cycle is measured and classified on its own.
// - Bytes enter and leave as 1200 baud serial frames with one start, eight data and one stop bit.
// - Each direction holds bytes in a 32-byte buffer.
// - With fewer than three bytes waiting, a packet is still sent and empty byte slots carry idle groups.
// - When the transmit buffer is empty after a packet, the transmitter key is released.
`timescale 1ns/10ps
`include "codec_cfg.svh"
module half_cycle_tone_packet_codec
	import codec_pkg::*;
#(
	parameter logic [16:0] P_LONG  = 17'(`HC_LONG_CYC),
	parameter logic [16:0] P_SHORT = 17'(`HC_SHORT_CYC),
	parameter logic [16:0] P_BIT   = 17'(`BIT_CYC)
)
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ser_rx,
	input  wire logic i_tone,
	output logic      o_ser_tx,
	output logic      o_tone,
	output logic      o_tx_key,
	output logic      o_pkt_rejected
);
	localparam logic [16:0] THRESH = (P_LONG + P_SHORT) >> 1;
	localparam logic [16:0] MEAS_MIN = P_SHORT >> 1;
	localparam logic [16:0] MEAS_MAX = P_LONG + (P_LONG >> 1);

	logic ser_s1, ser_s2, tone_s1, tone_s2, tone_d;
	logic urx_busy, next_urx_busy, urx_push, next_urx_push;
	logic [16:0] urx_timer, next_urx_timer;
	logic [3:0] urx_bit, next_urx_bit;
	logic [7:0] urx_shift, next_urx_shift;
	logic tf_pop, tf_full, tf_empty, rf_push, rf_full, rf_empty, rf_pop;
	logic [7:0] tf_rdata, rf_rdata, rf_wdata;
	logic [5:0] tf_count;
	tx_state_t enc_state, next_enc_state;
	logic [5:0] enc_idx, next_enc_idx;
	logic [16:0] enc_timer, next_enc_timer;
	logic [6:0] enc_pre, next_enc_pre;
	logic [1:0] enc_cnt, next_enc_cnt;
	logic [7:0] enc_byte, next_enc_byte;
	logic enc_null, next_enc_null, next_tone, next_key;
	logic [16:0] meas, next_meas;
	logic tone_edge, sym_evt, sym_void, sym_l;
	rx_state_t rx_state, next_rx_state;
	logic [13:0] rx_hist, next_rx_hist;
	logic [5:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_code, next_rx_code;
	logic [7:0] rx_byte, next_rx_byte;
	logic [23:0] rx_pkt, next_rx_pkt;
	logic [2:0] rx_real, next_rx_real;
	logic rx_hasd, next_rx_hasd, rx_hasn, next_rx_hasn, next_rej;
	logic [1:0] rx_pi, next_rx_pi;
	logic utx_busy, next_utx_busy, next_ser_tx;
	logic [16:0] utx_timer, next_utx_timer;
	logic [3:0] utx_bit, next_utx_bit;
	logic [9:0] utx_shift, next_utx_shift;

	// Two-stage synchronisers for the serial input and the sliced tone.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			{ser_s1, ser_s2, tone_s1, tone_s2, tone_d} <= 5'h18;
		else
			{ser_s1, ser_s2, tone_s1, tone_s2, tone_d} <= {i_ser_rx, ser_s1, i_tone, tone_s1, tone_s2};
	end

	// Serial receiver: samples mid-bit and pushes good frames to the transmit buffer.
	always_comb
	begin
		next_urx_busy = urx_busy;
		next_urx_timer = urx_timer;
		next_urx_bit = urx_bit;
		next_urx_shift = urx_shift;
		next_urx_push = 1'b0;
		if (!urx_busy)
		begin
			if (!ser_s2)
			begin
				next_urx_busy = 1'b1;
				next_urx_timer = P_BIT >> 1;
				next_urx_bit = 4'd0;
			end
		end
		else if (urx_timer != 17'd0)
			next_urx_timer = urx_timer - 17'd1;
		else
		begin
			next_urx_timer = P_BIT - 17'd1;
			next_urx_bit = urx_bit + 4'd1;
			if (urx_bit == 4'd0)
				next_urx_busy = !ser_s2;               // A glitch is not a start bit.
			else if (urx_bit == `SER_LAST_BIT)
			begin
				next_urx_busy = 1'b0;
				next_urx_push = ser_s2 && !tf_full;
			end
			else
				next_urx_shift = {ser_s2, urx_shift[7:1]};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			{urx_busy, urx_timer, urx_bit, urx_shift, urx_push} <= '0;
		else
			{urx_busy, urx_timer, urx_bit, urx_shift, urx_push} <=
				{next_urx_busy, next_urx_timer, next_urx_bit, next_urx_shift, next_urx_push};
	end

	// Transmit and receive byte buffers.
	codec_byte_fifo u_tx_fifo (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_push(urx_push),
		.i_wdata(urx_shift), .i_pop(tf_pop), .o_rdata(tf_rdata), .o_full(tf_full),
		.o_empty(tf_empty), .o_count(tf_count));
	codec_byte_fifo u_rx_fifo (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_push(rf_push),
		.i_wdata(rf_wdata), .i_pop(rf_pop), .o_rdata(rf_rdata), .o_full(rf_full),
		.o_empty(rf_empty), .o_count());

	// Encoder: picks the length of each new half at the end of the previous one.
	always_comb
	begin : enc_next
		logic [5:0] ni;
		logic [5:0] d;
		logic [3:0] code;
		logic       sym_long;
		ni = enc_idx + 6'd1;
		d = ni - `SYNC_HALVES;
		code = `CODE_NULL;
		sym_long = 1'b1;
		next_enc_state = enc_state;
		{next_enc_idx, next_enc_pre, next_enc_cnt} = {enc_idx, enc_pre, enc_cnt};
		{next_enc_byte, next_enc_null, next_tone, next_key} = {enc_byte, enc_null, o_tone, o_tx_key};
		next_enc_timer = enc_timer - 17'd1;
		tf_pop = 1'b0;
		if (enc_timer == 17'd0)
		begin
			next_tone = ~o_tone;
			unique case (enc_state)
				TX_OFF:
					if (!tf_empty)
					begin
						next_key = 1'b1;
						next_enc_state = TX_PRE;
						next_enc_pre = `PREAMBLE_HALVES - 7'd1;
					end
				TX_PRE:
					if (enc_pre != 7'd0)
						next_enc_pre = enc_pre - 7'd1;
					else
					begin
						next_enc_state = TX_PKT;
						next_enc_idx = 6'd0;
						next_enc_cnt = (tf_count >= `PKT_BYTES) ? 2'd3 : tf_count[1:0];
					end
				TX_PKT:
					if (enc_idx == `PKT_LAST_HALF)
					begin
						next_enc_idx = 6'd0;
						next_enc_cnt = (tf_count >= `PKT_BYTES) ? 2'd3 : tf_count[1:0];
						if (tf_empty)
						begin
							next_enc_state = TX_OFF;
							next_key = 1'b0;
						end
					end
					else
					begin
						next_enc_idx = ni;
						if (ni < `SYNC_HALVES)
							sym_long = (ni == `SYNC_HALVES - 6'd1);
						else
						begin
							if (d[3:0] == 4'h0)
							begin
								next_enc_null = (d[5:4] >= enc_cnt);
								tf_pop = !next_enc_null;
								next_enc_byte = tf_rdata;
							end
							else if (d[1:0] == 2'h0)
								next_enc_byte = {2'h0, enc_byte[7:2]};
							if (!next_enc_null)
								code = code_of(next_enc_byte[1:0]);
							sym_long = code[2'd3 - d[1:0]];
						end
					end
			endcase
			next_enc_timer = sym_long ? P_LONG - 17'd1 : P_SHORT - 17'd1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			enc_state <= TX_OFF;
			{enc_idx, enc_pre, enc_cnt, enc_byte, enc_null} <= 24'h0;
			{o_tone, o_tx_key} <= 2'h0;
			enc_timer <= P_LONG - 17'd1;
		end
		else
		begin
			enc_state <= next_enc_state;
			{enc_idx, enc_pre, enc_cnt} <= {next_enc_idx, next_enc_pre, next_enc_cnt};
			{enc_byte, enc_null, o_tone, o_tx_key} <= {next_enc_byte, next_enc_null, next_tone, next_key};
			enc_timer <= next_enc_timer;
		end
	end

	// Half-cycle measurement: each edge ends one half, a missing edge gives one void.
	assign tone_edge = tone_s2 ^ tone_d;
	assign sym_evt = tone_edge || (meas == MEAS_MAX);
	assign sym_void = !tone_edge || (meas < MEAS_MIN) || (meas > MEAS_MAX);
	assign sym_l = (meas >= THRESH);
	assign next_meas = tone_edge ? 17'd1 : (meas > MEAS_MAX) ? meas : meas + 17'd1;
	assign rf_wdata = rx_pkt[{rx_pi, 3'h0} +: 8];

	// Decoder: hunts for sync, gathers twelve groups, then releases the real bytes.
	always_comb
	begin : rx_next
		logic [3:0] code;
		logic [2:0] dec;
		logic [1:0] slot;
		code = {rx_code[2:0], sym_l};
		dec = dibit_of(code);
		slot = rx_cnt[5:4];
		next_rx_state = rx_state;
		{next_rx_hist, next_rx_cnt, next_rx_code} = {rx_hist, rx_cnt, rx_code};
		{next_rx_byte, next_rx_pkt, next_rx_real} = {rx_byte, rx_pkt, rx_real};
		{next_rx_hasd, next_rx_hasn, next_rx_pi} = {rx_hasd, rx_hasn, rx_pi};
		next_rej = 1'b0;
		rf_push = 1'b0;
		unique case (rx_state)
			RX_HUNT:
				if (sym_evt)
				begin
					next_rx_hist = sym_void ? 14'h0 : {rx_hist[12:0], sym_l};
					if (!sym_void && ({rx_hist[12:0], sym_l} == `SYNC_PATTERN))
					begin
						next_rx_state = RX_DATA;
						{next_rx_cnt, next_rx_real, next_rx_hasd, next_rx_hasn} = '0;
					end
				end
			RX_DATA:
				if (sym_evt)
				begin
					next_rx_code = code;
					next_rx_cnt = rx_cnt + 6'd1;
					if (rx_cnt[1:0] == 2'h3 && !sym_void)
					begin
						if (code == `CODE_NULL)
							next_rx_hasn = 1'b1;
						else if (dec[2])
						begin
							next_rx_byte = {dec[1:0], rx_byte[7:2]};
							next_rx_hasd = 1'b1;
						end
					end
					if (sym_void || (rx_cnt[1:0] == 2'h3 && code != `CODE_NULL && !dec[2]) ||
						(rx_cnt[3:0] == 4'hF && next_rx_hasd && next_rx_hasn))
					begin
						next_rx_state = RX_HUNT;
						next_rx_hist = 14'h0;
						next_rej = 1'b1;
					end
					else if (rx_cnt[3:0] == 4'hF)
					begin
						next_rx_real[slot] = next_rx_hasd;
						next_rx_pkt[{slot, 3'h0} +: 8] = next_rx_byte;
						{next_rx_hasd, next_rx_hasn} = 2'h0;
						if (rx_cnt == `DATA_LAST_HALF)
						begin
							next_rx_state = RX_PUSH;
							next_rx_pi = 2'h0;
						end
					end
				end
			RX_PUSH:
			begin
				rf_push = rx_real[rx_pi] && !rf_full;
				next_rx_pi = rx_pi + 2'h1;
				if (rx_pi == 2'h2)
				begin
					next_rx_state = RX_HUNT;
					next_rx_hist = 14'h0;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_state <= RX_HUNT;
			{rx_hist, rx_cnt, rx_code, rx_byte} <= 32'h0;
			{rx_pkt, rx_real, rx_hasd, rx_hasn, rx_pi, o_pkt_rejected, meas} <= '0;
		end
		else
		begin
			rx_state <= next_rx_state;
			{rx_hist, rx_cnt, rx_code, rx_byte} <=
				{next_rx_hist, next_rx_cnt, next_rx_code, next_rx_byte};
			{rx_pkt, rx_real, rx_hasd, rx_hasn, rx_pi, o_pkt_rejected, meas} <=
				{next_rx_pkt, next_rx_real, next_rx_hasd, next_rx_hasn, next_rx_pi, next_rej, next_meas};
		end
	end

	// Serial transmitter: sends decoded bytes as start, eight data and stop bits.
	always_comb
	begin
		{next_utx_busy, next_utx_timer, next_utx_bit, next_utx_shift} = {utx_busy, utx_timer, utx_bit, utx_shift};
		next_ser_tx = o_ser_tx;
		rf_pop = 1'b0;
		if (!utx_busy)
		begin
			if (!rf_empty)
			begin
				rf_pop = 1'b1;
				next_utx_busy = 1'b1;
				next_utx_shift = {1'b1, rf_rdata, 1'b0};
				next_utx_timer = P_BIT - 17'd1;
				next_utx_bit = 4'd0;
				next_ser_tx = 1'b0;
			end
		end
		else if (utx_timer != 17'd0)
			next_utx_timer = utx_timer - 17'd1;
		else if (utx_bit == `SER_LAST_BIT)
			next_utx_busy = 1'b0;
		else
		begin
			next_utx_shift = {1'b1, utx_shift[9:1]};
			next_ser_tx = utx_shift[1];
			next_utx_bit = utx_bit + 4'd1;
			next_utx_timer = P_BIT - 17'd1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			{utx_busy, utx_timer, utx_bit, utx_shift, o_ser_tx} <= {32'h0, 1'b1};
		else
			{utx_busy, utx_timer, utx_bit, utx_shift, o_ser_tx} <=
				{next_utx_busy, next_utx_timer, next_utx_bit, next_utx_shift, next_ser_tx};
	end

	// Checking helpers: length of each sent half measured from the tone itself.
	logic        tone_q;
	logic [16:0] sent_len;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			{tone_q, sent_len} <= '0;
		else
			{tone_q, sent_len} <= {o_tone, (o_tone != tone_q) ? 17'd1 : sent_len + 17'd1};
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_half_length: assert property ((o_tone != tone_q) |-> (sent_len == P_LONG || sent_len == P_SHORT))
		else $error("Sent half-cycle has an illegal length.");
	chk_idle_long: assert property ((o_tone != tone_q) && !$past(o_tx_key) |-> sent_len == P_LONG)
		else $error("Idle tone half is not long.");
	chk_sync_shorts: assert property ((o_tone != tone_q) && $past(enc_state) == TX_PKT &&
		$past(enc_idx) inside {[6'd1:6'd12]} |-> sent_len == P_SHORT)
		else $error("Sync middle half is not short.");
	chk_key_release: assert property ($fell(o_tx_key) |-> $past(enc_idx) == `PKT_LAST_HALF &&
		$past(enc_state) == TX_PKT && $past(tf_empty))
		else $error("Key released outside a packet end with an empty buffer.");
	chk_pop_slot: assert property (tf_pop |-> enc_idx inside {6'd13, 6'd29, 6'd45} ##1 enc_state == TX_PKT)
		else $error("Transmit byte taken outside a byte slot start.");
	chk_void_reject: assert property (rx_state == RX_DATA && sym_evt && sym_void |=>
		rx_state == RX_HUNT && o_pkt_rejected ##1 !o_pkt_rejected)
		else $error("Void half did not reject the packet.");
	chk_sync_hunt: assert property (rx_state == RX_HUNT && sym_evt && !sym_void &&
		{rx_hist[12:0], sym_l} == `SYNC_PATTERN |=> rx_state == RX_DATA && rx_cnt == 6'd0)
		else $error("Sync pattern missed.");
	chk_push_real: assert property (rf_push |-> rx_state == RX_PUSH && rx_real[rx_pi])
		else $error("Null or stray byte delivered.");
	chk_class_mid: assert property (tone_edge && meas >= MEAS_MIN && meas < THRESH |-> !sym_l && !sym_void)
		else $error("Short half misclassified.");
	chk_ser_start: assert property ($rose(utx_busy) |-> !o_ser_tx ##1 !o_ser_tx)
		else $error("Serial frame lacks a start bit.");

	cov_sync_found: cover property (rx_state == RX_HUNT ##1 rx_state == RX_DATA);
	cov_byte_out: cover property (rf_push);
	cov_reject: cover property (o_pkt_rejected);
	cov_key_off: cover property ($fell(o_tx_key));

endmodule : half_cycle_tone_packet_codec

//--- codec_cfg.svh
// Constants of the half-cycle tone packet codec: timing, framing and code table.
`ifndef CODEC_CFG_SVH
`define CODEC_CFG_SVH

// System clock period.
`define CLK_PERIOD_NS    10
// Nominal half-cycle lengths of the tone, in nanoseconds and in clock cycles.
`define HC_LONG_NS       500000
`define HC_SHORT_NS      250000
`define HC_LONG_CYC      ((`HC_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HC_SHORT_CYC     ((`HC_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Serial stream rate and bit time.
`define BAUD_RATE        1200
`define BIT_NS           (1000000000 / `BAUD_RATE)
`define BIT_CYC          (`BIT_NS / `CLK_PERIOD_NS)
`define SER_LAST_BIT     4'd9
// Long half-cycles sent after keying the transmitter, ahead of the first packet.
`define PREAMBLE_HALVES  7'd100
// Packet framing: 14 sync halves, then 48 data halves.
`define SYNC_HALVES      6'd14
`define PKT_LAST_HALF    6'd61
`define DATA_LAST_HALF   6'd47
`define PKT_BYTES        6'd3
// Sync pattern L S*12 L, oldest half in the top bit, 1 = long.
`define SYNC_PATTERN     14'h2001
// Group codes, first half in bit 3, 1 = long.
`define CODE_NULL        4'hF
`define CODE_D0          4'h3
`define CODE_D1          4'h5
`define CODE_D2          4'h6
`define CODE_D3          4'h9
// Byte buffer geometry.
`define FIFO_DEPTH       32
`define FIFO_AW          5

`endif

//--- codec_pkg.sv
// Types and group code table shared by the codec logic.
package codec_pkg;
`include "codec_cfg.svh"

	typedef enum logic [1:0] {TX_OFF, TX_PRE, TX_PKT} tx_state_t;
	typedef enum logic [1:0] {RX_HUNT, RX_DATA, RX_PUSH} rx_state_t;

	// Maps a dibit to the four-half group code that carries it.
	function automatic logic [3:0] code_of(input logic [1:0] dibit);
		unique case (dibit)
			2'h0: code_of = `CODE_D0;
			2'h1: code_of = `CODE_D1;
			2'h2: code_of = `CODE_D2;
			2'h3: code_of = `CODE_D3;
		endcase
	endfunction : code_of

	// Returns {valid, dibit} for a received group code.
	function automatic logic [2:0] dibit_of(input logic [3:0] code);
		unique case (code)
			`CODE_D0: dibit_of = 3'h4;
			`CODE_D1: dibit_of = 3'h5;
			`CODE_D2: dibit_of = 3'h6;
			`CODE_D3: dibit_of = 3'h7;
			default:  dibit_of = 3'h0;
		endcase
	endfunction : dibit_of

endpackage : codec_pkg

//--- codec_byte_fifo.sv
// Byte FIFO of fixed depth with show-ahead read data.
`timescale 1ns/10ps
`include "codec_cfg.svh"
module codec_byte_fifo
(
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_push,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_pop,
	output logic      [7:0]           o_rdata,
	output logic                      o_full,
	output logic                      o_empty,
	output logic      [`FIFO_AW:0]    o_count
);
	logic [7:0]          mem [`FIFO_DEPTH];
	logic [`FIFO_AW-1:0] wr_ptr;
	logic [`FIFO_AW-1:0] rd_ptr;
	logic [`FIFO_AW:0]   next_count;
	logic                do_push;
	logic                do_pop;

	// Writes into a full buffer and reads from an empty one are ignored.
	always_comb
	begin
		do_push    = i_push && !o_full;
		do_pop     = i_pop && !o_empty;
		next_count = o_count + {`FIFO_AW'(0), do_push} - {`FIFO_AW'(0), do_pop};
	end

	// Pointers and occupancy.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			o_count <= '0;
		end
		else
		begin
			wr_ptr  <= wr_ptr + `FIFO_AW'(do_push);
			rd_ptr  <= rd_ptr + `FIFO_AW'(do_pop);
			o_count <= next_count;
		end
	end

	// Storage array.
	always_ff @(posedge i_clk)
	begin
		if (do_push)
			mem[wr_ptr] <= i_wdata;
	end

	assign o_rdata = mem[rd_ptr];
	assign o_full  = (o_count == (`FIFO_AW+1)'(`FIFO_DEPTH));
	assign o_empty = (o_count == '0);

endmodule : codec_byte_fifo

//--- tone_partner.sv
// Far-side modem model that sends packets of long and short half-cycles on the tone line.
`timescale 1ns/10ps
module tone_partner
#(
	parameter int P_LONG  = 40,
	parameter int P_SHORT = 20
)
(
	input  wire logic i_clk,
	output logic      o_tone
);
	int   q[$];
	int   cnt  = 0;
	int   len  = P_LONG;
	logic tone = 1'b0;

	assign o_tone = tone;

	// Maps a dibit to its group code, first half in the top bit, 1 = long.
	function automatic logic [3:0] code_for(input logic [1:0] d);
		return (d == 2'h0) ? 4'h3 : (d == 2'h1) ? 4'h5 : (d == 2'h2) ? 4'h6 : 4'h9;
	endfunction : code_for

	// Queues one group of four halves, first half first.
	task automatic send_group(input logic [3:0] c);
		for (int i = 3; i >= 0; i--)
			q.push_back(c[i] ? P_LONG : P_SHORT);
	endtask : send_group

	// Queues the opening pattern of a packet: one long, twelve shorts, one long.
	task automatic send_sync();
		q.push_back(P_LONG);
		repeat (12) q.push_back(P_SHORT);
		q.push_back(P_LONG);
	endtask : send_sync

	// Queues one half far longer than a long one, which a receiver must treat as void.
	task automatic send_void();
		q.push_back(3 * P_LONG);
	endtask : send_void

	// Queues a byte as four groups, least significant dibit first, or four idle groups.
	task automatic send_byte(input logic [7:0] b, input bit is_null);
		for (int k = 0; k < 4; k++)
			send_group(is_null ? 4'hF : code_for(b[2*k +: 2]));
	endtask : send_byte

	// Ends each half after its length; with nothing queued the line carries unbroken longs.
	always @(negedge i_clk)
	begin
		cnt = cnt + 1;
		if (cnt >= len)
		begin
			cnt  = 0;
			tone = ~tone;
			len  = (q.size() > 0) ? q.pop_front() : P_LONG;
		end
	end
endmodule : tone_partner

//--- tb_half_cycle_tone_packet_codec.sv
// Self-checking testbench of the half-cycle tone packet codec.
`timescale 1ns/10ps
module tb_half_cycle_tone_packet_codec;
	localparam int P_LONG  = 40;
	localparam int P_SHORT = 20;
	localparam int P_BIT   = 16;

	logic i_clk;
	logic i_rst_n;
	logic i_ser_rx;
	logic tone_in;
	logic o_ser_tx;
	logic o_tone;
	logic o_tx_key;
	logic o_pkt_rejected;
	int   num_errors = 0;
	int   checked    = 0;
	int   rej_cnt    = 0;
	int   low_cycles = 0;
	bit   exp_q[$];

	half_cycle_tone_packet_codec
	#(
		.P_LONG  (17'(P_LONG)),
		.P_SHORT (17'(P_SHORT)),
		.P_BIT   (17'(P_BIT))
	)
	u_half_cycle_tone_packet_codec
	(
		.i_clk          (i_clk),
		.i_rst_n        (i_rst_n),
		.i_ser_rx       (i_ser_rx),
		.i_tone         (tone_in),
		.o_ser_tx       (o_ser_tx),
		.o_tone         (o_tone),
		.o_tx_key       (o_tx_key),
		.o_pkt_rejected (o_pkt_rejected)
	);

	tone_partner u_tone_partner
	(
		.i_clk  (i_clk),
		.o_tone (tone_in)
	);

	// Makes the 100 MHz clock.
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Counts reject pulses and cycles in which the serial output is not idle.
	always @(negedge i_clk)
	begin
		if (o_pkt_rejected === 1'b1)
			rej_cnt++;
		if (o_ser_tx !== 1'b1)
			low_cycles++;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// Compares a seen value with the expected one.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	// Counts a wait that ran out of time and closes the run.
	task automatic timed_out(input string name);
		num_errors++;
		$display("[ERR] %s expected event seen timeout", name);
		test_done();
	endtask : timed_out

	// Sends one serial frame: start, eight bits first bit lowest, stop.
	task automatic ser_send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			i_ser_rx = f[i];
			repeat (P_BIT) @(negedge i_clk);
		end
	endtask : ser_send

	// Receives one serial frame and compares its byte and stop bit.
	task automatic ser_expect(input logic [7:0] exp);
		logic [7:0] b;
		int         n;
		n = 0;
		while (o_ser_tx !== 1'b0)
		begin
			@(negedge i_clk);
			n++;
			if (n > 6000) timed_out("serial start");
		end
		repeat (P_BIT / 2) @(negedge i_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (P_BIT) @(negedge i_clk);
			b[i] = o_ser_tx;
		end
		repeat (P_BIT) @(negedge i_clk);
		check("serial byte", {24'h0, b}, {24'h0, exp});
		check("stop bit", {31'h0, o_ser_tx}, 32'h1);
	endtask : ser_expect

	// Measures the length of the next transmitted half in clock cycles.
	task automatic next_half(output int n);
		logic prev;
		prev = o_tone;
		n = 0;
		while (o_tone === prev)
		begin
			@(negedge i_clk);
			n++;
			if (n > 4 * P_LONG) timed_out("tone half");
		end
	endtask : next_half

	// Adds one group, or the opening pattern, to the expected half list.
	task automatic exp_group(input logic [3:0] c);
		for (int i = 3; i >= 0; i--)
			exp_q.push_back(c[i]);
	endtask : exp_group

	task automatic exp_sync();
		exp_group(4'h8);
		exp_group(4'h0);
		exp_group(4'h0);
		exp_q.push_back(1'b0);
		exp_q.push_back(1'b1);
	endtask : exp_sync

	// Checks outputs in reset and the idle tone with the key off after release.
	task automatic t_reset();
		int n;
		check("reset ser_tx", {31'h0, o_ser_tx}, 32'h1);
		check("reset key", {31'h0, o_tx_key}, 32'h0);
		check("reset reject", {31'h0, o_pkt_rejected}, 32'h0);
		i_rst_n = 1'b1;
		next_half(n);
		next_half(n);
		check("idle half", n, P_LONG);
		check("idle key", {31'h0, o_tx_key}, 32'h0);
	endtask : t_reset

	// A packet with a null byte between two data bytes delivers just the data bytes.
	task automatic t_decode_good();
		int rej0;
		rej0 = rej_cnt;
		u_tone_partner.send_sync();
		u_tone_partner.send_byte(8'h5A, 1'b0);
		u_tone_partner.send_byte(8'h00, 1'b1);
		u_tone_partner.send_byte(8'hC3, 1'b0);
		ser_expect(8'h5A);
		ser_expect(8'hC3);
		check("good packet rejects", rej_cnt - rej0, 0);
	endtask : t_decode_good

	// Packets holding an illegal group, a byte mixing data and null groups or an over-long half
	// are dropped whole with one reject pulse each; 4'hF in the list stands for the over-long half.
	task automatic t_decode_void();
		logic [3:0] bad [5] = '{4'h0, 4'hE, 4'hC, 4'h3, 4'hF};
		int         rej0;
		int         low0;
		foreach (bad[j])
		begin
			rej0 = rej_cnt;
			low0 = low_cycles;
			u_tone_partner.send_sync();
			u_tone_partner.send_byte(8'h5A, 1'b0);
			if (bad[j] == 4'hF)
				u_tone_partner.send_void();
			else
				u_tone_partner.send_group(bad[j]);
			repeat (7) u_tone_partner.send_group(4'hF);
			for (int n = 0; u_tone_partner.q.size() > 0; n++)
			begin
				@(negedge i_clk);
				if (n > 5000) timed_out("partner drain");
			end
			repeat (4 * P_LONG) @(negedge i_clk);
			check("void rejects", rej_cnt - rej0, 1);
			check("void output", low_cycles - low0, 0);
		end
	endtask : t_decode_void

	// Four bytes give preamble, a full packet, then a packet padded with idle groups.
	task automatic t_encode();
		logic [7:0] data [4] = '{8'hB4, 8'h00, 8'hFF, 8'h1E};
		int         n;
		repeat (100) exp_q.push_back(1'b1);
		for (int b = 0; b < 6; b++)
		begin
			if (b % 3 == 0) exp_sync();
			for (int k = 0; k < 4; k++)
				exp_group(b < 4 ? u_tone_partner.code_for(data[b][2*k +: 2]) : 4'hF);
		end
		fork
			foreach (data[b]) ser_send(data[b]);
			begin
				for (n = 0; o_tx_key !== 1'b1; n++)
				begin
					@(negedge i_clk);
					if (n > 2000) timed_out("key up");
				end
				foreach (exp_q[i])
				begin
					next_half(n);
					check("tx half", n, exp_q[i] ? P_LONG : P_SHORT);
					if (i == 161) check("key between", {31'h0, o_tx_key}, 32'h1);
				end
				check("key released", {31'h0, o_tx_key}, 32'h0);
			end
		join
	endtask : t_encode

	// Runs the scenarios in turn.
	initial
	begin
		i_rst_n  = 1'b0;
		i_ser_rx = 1'b1;
		repeat (4) @(negedge i_clk);
		t_reset();
		t_decode_good();
		t_decode_void();
		t_encode();
		test_done();
	end
endmodule : tb_half_cycle_tone_packet_codec
